// file: logic/cmer_consts.vh
`ifndef CMER_CONSTS_VH
`define CMER_CONSTS_VH

// widths fixed by the memory word and its check bits
`define CMER_DATA_W 32
`define CMER_ECC_W 7
`define CMER_HAM_W 6

// recovery sequencer state codes
`define CMER_ST_IDLE 2'h0
`define CMER_ST_FLUSH 2'h1
`define CMER_ST_WB 2'h2
`define CMER_ST_REFETCH 2'h3

// cause bit positions of the local interrupt
`define CMER_CAUSE_IC 0
`define CMER_CAUSE_INSTR_CLOSELY_COUPLED_MEM 1
`define CMER_CAUSE_DATA_CLOSELY_COUPLED_MEM 2

// counter increments
`define CMER_INC_NONE 2'h0
`define CMER_INC_ONE 2'h1

`endif

// file: logic/cmer_recovery.v
// Behaviour
// - count every instruction-cache fetch correctable error
// - icache counter at threshold raises local interrupt
// - icache error invalidates every line of set
// - icache error: refetch flush, pipeline flush, refill
// - icache counting covers all fetches, executed or not
// - icache single and double errors both recoverable
// - count every instruction memory fetch correctable error
// - instruction memory counter at threshold raises interrupt
// - instr memory: flush, flush, write back, refetch
// - instr memory fetch errors use flush, not inline
// - instr memory counting covers every fetch
// - count data memory load/store correctable errors
// - data memory counter at threshold raises interrupt
// - data memory errors corrected inline, written back
// - data memory handling only for non-speculative accesses
// - DMA read instr memory error: count, interrupt, write back
// - DMA read data memory error: count, interrupt, write back
// - DMA writes whole words, fresh check bits, no check
// - counters hold error count only, no location
`timescale 1ns/1ps
`include "cmer_consts.vh"

module cmer_recovery #(
	parameter CNT_W = 16,
	parameter ADDR_W = 16,
	parameter SET_W = 6
) (
	input wire core_clk,
	input wire rst_n,
	input wire ic_fetch_err,
	input wire [SET_W-1:0] ic_err_set,
	input wire instr_closely_coupled_mem_fetch_err,
	input wire [ADDR_W-1:0] instr_closely_coupled_mem_fetch_addr,
	input wire [`CMER_DATA_W-1:0] instr_closely_coupled_mem_fetch_fix,
	input wire data_closely_coupled_mem_ls_err,
	input wire data_closely_coupled_mem_ls_spec,
	input wire [ADDR_W-1:0] data_closely_coupled_mem_ls_addr,
	input wire [`CMER_DATA_W-1:0] data_closely_coupled_mem_ls_fix,
	input wire dma_rd_err,
	input wire dma_rd_to_instr_closely_coupled_mem,
	input wire [ADDR_W-1:0] dma_rd_addr,
	input wire [`CMER_DATA_W-1:0] dma_rd_fix,
	input wire dma_wr_en,
	input wire dma_wr_to_instr_closely_coupled_mem,
	input wire [ADDR_W-1:0] dma_wr_addr,
	input wire [`CMER_DATA_W-1:0] dma_wr_data,
	input wire [CNT_W-1:0] ic_thresh,
	input wire [CNT_W-1:0] instr_closely_coupled_mem_thresh,
	input wire [CNT_W-1:0] data_closely_coupled_mem_thresh,
	output reg [CNT_W-1:0] ic_cnt_q,
	output reg [CNT_W-1:0] instr_closely_coupled_mem_cnt_q,
	output reg [CNT_W-1:0] data_closely_coupled_mem_cnt_q,
	output reg corr_err_irq_q,
	output reg [2:0] irq_cause_q,
	output reg ic_inval_q,
	output reg [SET_W-1:0] ic_inval_set_q,
	output reg refetch_pc_flush_q,
	output reg pipe_flush_q,
	output reg ic_refill_q,
	output reg instr_closely_coupled_mem_refetch_q,
	output reg rec_busy_q,
	output reg instr_closely_coupled_mem_wr_q,
	output reg [ADDR_W-1:0] instr_closely_coupled_mem_wr_addr_q,
	output reg [`CMER_DATA_W-1:0] instr_closely_coupled_mem_wr_data_q,
	output reg [`CMER_ECC_W-1:0] instr_closely_coupled_mem_wr_ecc_q,
	output reg data_closely_coupled_mem_wr_q,
	output reg [ADDR_W-1:0] data_closely_coupled_mem_wr_addr_q,
	output reg [`CMER_DATA_W-1:0] data_closely_coupled_mem_wr_data_q,
	output reg [`CMER_ECC_W-1:0] data_closely_coupled_mem_wr_ecc_q
);

	// single-error-correct double-detect check bits for one word
	function [`CMER_ECC_W-1:0] cmer_ecc;
		input [`CMER_DATA_W-1:0] d;
		integer i;
		integer k;
		integer p;
		reg [`CMER_ECC_W-1:0] c;
		begin
			c = {`CMER_ECC_W{1'b0}};
			p = 2;
			for (i = 0; i < `CMER_DATA_W; i = i + 1) begin
				p = p + 1;
				// skip code positions owned by check bits
				if ((p & (p - 1)) == 0)
					p = p + 1;
				for (k = 0; k < `CMER_HAM_W; k = k + 1) begin
					if (p[k])
						c[k] = c[k] ^ d[i];
				end
			end
			c[`CMER_HAM_W] = ^{d, c[`CMER_HAM_W-1:0]};
			cmer_ecc = c;
		end
	endfunction

	// saturating add; a wrapped count would re-fire the interrupt
	function [CNT_W-1:0] cmer_sat;
		input [CNT_W-1:0] cnt;
		input [1:0] inc;
		reg [CNT_W:0] sum;
		begin
			sum = {1'b0, cnt} + {{(CNT_W-1){1'b0}}, inc};
			if (sum[CNT_W])
				cmer_sat = {CNT_W{1'b1}};
			else
				cmer_sat = sum[CNT_W-1:0];
		end
	endfunction

	// crossing test so a step of two cannot jump over the threshold
	function cmer_hit;
		input [CNT_W-1:0] cnt;
		input [CNT_W-1:0] nxt;
		input [CNT_W-1:0] th;
		begin
			cmer_hit = (cnt < th) && (nxt >= th);
		end
	endfunction

	wire ls_new;
	wire dma_rd_i;
	wire dma_rd_d;
	wire dma_wr_i;
	wire dma_wr_d;
	wire [1:0] ic_inc;
	wire [1:0] instr_closely_coupled_mem_inc;
	wire [1:0] data_closely_coupled_mem_inc;
	wire [CNT_W-1:0] ic_cnt_d;
	wire [CNT_W-1:0] instr_closely_coupled_mem_cnt_d;
	wire [CNT_W-1:0] data_closely_coupled_mem_cnt_d;
	wire [2:0] hit;
	wire instr_closely_coupled_mem_port_dma;
	wire wb_go;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg rec_instr_closely_coupled_mem_q;
	reg [ADDR_W-1:0] rec_addr_q;
	reg [`CMER_DATA_W-1:0] rec_data_q;
	reg [SET_W-1:0] rec_set_q;
	reg pend_q;
	reg [ADDR_W-1:0] pend_addr_q;
	reg [`CMER_DATA_W-1:0] pend_data_q;
	reg iw_en;
	reg [ADDR_W-1:0] iw_addr;
	reg [`CMER_DATA_W-1:0] iw_data;
	reg dw_en;
	reg [ADDR_W-1:0] dw_addr;
	reg [`CMER_DATA_W-1:0] dw_data;
	reg ls_taken;
	reg pend_taken;

	// speculative accesses never touch counters or memory
	assign ls_new = data_closely_coupled_mem_ls_err && !data_closely_coupled_mem_ls_spec;
	assign dma_rd_i = dma_rd_err && dma_rd_to_instr_closely_coupled_mem;
	assign dma_rd_d = dma_rd_err && !dma_rd_to_instr_closely_coupled_mem;
	assign dma_wr_i = dma_wr_en && dma_wr_to_instr_closely_coupled_mem;
	assign dma_wr_d = dma_wr_en && !dma_wr_to_instr_closely_coupled_mem;

	// per-memory increments; counters keep a tally only, never an address
	assign ic_inc = {1'b0, ic_fetch_err};
	assign instr_closely_coupled_mem_inc = {1'b0, instr_closely_coupled_mem_fetch_err} + {1'b0, dma_rd_i};
	assign data_closely_coupled_mem_inc = {1'b0, ls_new} + {1'b0, dma_rd_d};
	assign ic_cnt_d = cmer_sat(ic_cnt_q, ic_inc);
	assign instr_closely_coupled_mem_cnt_d = cmer_sat(instr_closely_coupled_mem_cnt_q, instr_closely_coupled_mem_inc);
	assign data_closely_coupled_mem_cnt_d = cmer_sat(data_closely_coupled_mem_cnt_q, data_closely_coupled_mem_inc);

	// threshold reached on this update; a zero threshold never fires
	assign hit[`CMER_CAUSE_IC] = cmer_hit(ic_cnt_q, ic_cnt_d, ic_thresh);
	assign hit[`CMER_CAUSE_INSTR_CLOSELY_COUPLED_MEM] = cmer_hit(instr_closely_coupled_mem_cnt_q, instr_closely_coupled_mem_cnt_d, instr_closely_coupled_mem_thresh);
	assign hit[`CMER_CAUSE_DATA_CLOSELY_COUPLED_MEM] = cmer_hit(data_closely_coupled_mem_cnt_q, data_closely_coupled_mem_cnt_d, data_closely_coupled_mem_thresh);

	// dma owns the instruction memory port; the sequencer waits for it
	assign instr_closely_coupled_mem_port_dma = dma_wr_i || dma_rd_i;
	assign wb_go = (state_q == `CMER_ST_WB) && !instr_closely_coupled_mem_port_dma;

	// counters and local interrupt pulse
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ic_cnt_q <= {CNT_W{1'b0}};
			instr_closely_coupled_mem_cnt_q <= {CNT_W{1'b0}};
			data_closely_coupled_mem_cnt_q <= {CNT_W{1'b0}};
			corr_err_irq_q <= 1'b0;
			irq_cause_q <= 3'h0;
		end else begin
			ic_cnt_q <= ic_cnt_d;
			instr_closely_coupled_mem_cnt_q <= instr_closely_coupled_mem_cnt_d;
			data_closely_coupled_mem_cnt_q <= data_closely_coupled_mem_cnt_d;
			corr_err_irq_q <= |hit;
			irq_cause_q <= hit;
		end
	end

	// fetch recovery sequencer: flush first, inline fix would cost a cycle
	always @* begin
		state_d = state_q;
		case (state_q)
		`CMER_ST_IDLE: begin
			if (ic_fetch_err || instr_closely_coupled_mem_fetch_err)
				state_d = `CMER_ST_FLUSH;
		end
		`CMER_ST_FLUSH: begin
			if (rec_instr_closely_coupled_mem_q)
				state_d = `CMER_ST_WB;
			else
				state_d = `CMER_ST_REFETCH;
		end
		`CMER_ST_WB: begin
			if (wb_go)
				state_d = `CMER_ST_REFETCH;
		end
		`CMER_ST_REFETCH: begin
			state_d = `CMER_ST_IDLE;
		end
		default: begin
			state_d = `CMER_ST_IDLE;
		end
		endcase
	end

	// capture the failing fetch; later errors during recovery are counted only
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= `CMER_ST_IDLE;
			rec_instr_closely_coupled_mem_q <= 1'b0;
			rec_addr_q <= {ADDR_W{1'b0}};
			rec_data_q <= {`CMER_DATA_W{1'b0}};
			rec_set_q <= {SET_W{1'b0}};
		end else begin
			state_q <= state_d;
			if (state_q == `CMER_ST_IDLE && (ic_fetch_err || instr_closely_coupled_mem_fetch_err)) begin
				// instruction memory wins if both fail together
				rec_instr_closely_coupled_mem_q <= instr_closely_coupled_mem_fetch_err;
				rec_addr_q <= instr_closely_coupled_mem_fetch_addr;
				rec_data_q <= instr_closely_coupled_mem_fetch_fix;
				rec_set_q <= ic_err_set;
			end
		end
	end

	// one-cycle control pulses toward the pipeline and the cache, plus the rec_busy_q level held through recovery
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ic_inval_q <= 1'b0;
			ic_inval_set_q <= {SET_W{1'b0}};
			refetch_pc_flush_q <= 1'b0;
			pipe_flush_q <= 1'b0;
			ic_refill_q <= 1'b0;
			instr_closely_coupled_mem_refetch_q <= 1'b0;
			rec_busy_q <= 1'b0;
		end else begin
			ic_inval_q <= (state_d == `CMER_ST_FLUSH) && !instr_closely_coupled_mem_fetch_err;
			ic_inval_set_q <= ic_err_set;
			refetch_pc_flush_q <= (state_d == `CMER_ST_FLUSH);
			pipe_flush_q <= (state_d == `CMER_ST_FLUSH);
			ic_refill_q <= (state_d == `CMER_ST_REFETCH) && !rec_instr_closely_coupled_mem_q;
			instr_closely_coupled_mem_refetch_q <= (state_d == `CMER_ST_REFETCH) && rec_instr_closely_coupled_mem_q;
			rec_busy_q <= (state_d != `CMER_ST_IDLE);
		end
	end

	// instruction memory write port: dma write, dma fix, fetch fix
	always @* begin
		iw_en = 1'b0;
		iw_addr = {ADDR_W{1'b0}};
		iw_data = {`CMER_DATA_W{1'b0}};
		if (dma_wr_i) begin
			iw_en = 1'b1;
			iw_addr = dma_wr_addr;
			iw_data = dma_wr_data;
		end else if (dma_rd_i) begin
			iw_en = 1'b1;
			iw_addr = dma_rd_addr;
			iw_data = dma_rd_fix;
		end else if (wb_go) begin
			iw_en = 1'b1;
			iw_addr = rec_addr_q;
			iw_data = rec_data_q;
		end
	end

	// data memory write port; a blocked load/store fix waits one slot
	always @* begin
		dw_en = 1'b0;
		dw_addr = {ADDR_W{1'b0}};
		dw_data = {`CMER_DATA_W{1'b0}};
		ls_taken = 1'b0;
		pend_taken = 1'b0;
		if (dma_wr_d) begin
			dw_en = 1'b1;
			dw_addr = dma_wr_addr;
			dw_data = dma_wr_data;
		end else if (dma_rd_d) begin
			dw_en = 1'b1;
			dw_addr = dma_rd_addr;
			dw_data = dma_rd_fix;
		end else if (pend_q) begin
			dw_en = 1'b1;
			dw_addr = pend_addr_q;
			dw_data = pend_data_q;
			pend_taken = 1'b1;
		end else if (ls_new) begin
			dw_en = 1'b1;
			dw_addr = data_closely_coupled_mem_ls_addr;
			dw_data = data_closely_coupled_mem_ls_fix;
			ls_taken = 1'b1;
		end
	end

	// single deferral slot; keeps the load/store fix when dma holds the port
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			pend_addr_q <= {ADDR_W{1'b0}};
			pend_data_q <= {`CMER_DATA_W{1'b0}};
		end else if (ls_new && !ls_taken) begin
			pend_q <= 1'b1;
			pend_addr_q <= data_closely_coupled_mem_ls_addr;
			pend_data_q <= data_closely_coupled_mem_ls_fix;
		end else if (pend_taken) begin
			pend_q <= 1'b0;
		end
	end

	// registered write ports; check bits always regenerated, never checked
	always @(posedge core_clk) begin
		if (!rst_n) begin
			instr_closely_coupled_mem_wr_q <= 1'b0;
			instr_closely_coupled_mem_wr_addr_q <= {ADDR_W{1'b0}};
			instr_closely_coupled_mem_wr_data_q <= {`CMER_DATA_W{1'b0}};
			instr_closely_coupled_mem_wr_ecc_q <= {`CMER_ECC_W{1'b0}};
			data_closely_coupled_mem_wr_q <= 1'b0;
			data_closely_coupled_mem_wr_addr_q <= {ADDR_W{1'b0}};
			data_closely_coupled_mem_wr_data_q <= {`CMER_DATA_W{1'b0}};
			data_closely_coupled_mem_wr_ecc_q <= {`CMER_ECC_W{1'b0}};
		end else begin
			instr_closely_coupled_mem_wr_q <= iw_en;
			instr_closely_coupled_mem_wr_addr_q <= iw_addr;
			instr_closely_coupled_mem_wr_data_q <= iw_data;
			instr_closely_coupled_mem_wr_ecc_q <= cmer_ecc(iw_data);
			data_closely_coupled_mem_wr_q <= dw_en;
			data_closely_coupled_mem_wr_addr_q <= dw_addr;
			data_closely_coupled_mem_wr_data_q <= dw_data;
			data_closely_coupled_mem_wr_ecc_q <= cmer_ecc(dw_data);
		end
	end

endmodule

// file: sim/cmer_recovery_properties.sv
`timescale 1ns/1ps
`include "cmer_consts.vh"
module cmer_recovery_properties #(
	parameter CNT_W = 16,
	parameter ADDR_W = 16,
	parameter SET_W = 6
) (
	input wire core_clk,
	input wire rst_n,
	input wire ic_fetch_err,
	input wire [SET_W-1:0] ic_err_set,
	input wire instr_closely_coupled_mem_fetch_err,
	input wire data_closely_coupled_mem_ls_err,
	input wire data_closely_coupled_mem_ls_spec,
	input wire dma_rd_err,
	input wire dma_wr_en,
	input wire dma_wr_to_instr_closely_coupled_mem,
	input wire [ADDR_W-1:0] dma_wr_addr,
	input wire [`CMER_DATA_W-1:0] dma_wr_data,
	input wire [CNT_W-1:0] ic_thresh,
	input wire [CNT_W-1:0] ic_cnt_q,
	input wire [CNT_W-1:0] data_closely_coupled_mem_cnt_q,
	input wire corr_err_irq_q,
	input wire [2:0] irq_cause_q,
	input wire ic_inval_q,
	input wire [SET_W-1:0] ic_inval_set_q,
	input wire refetch_pc_flush_q,
	input wire pipe_flush_q,
	input wire ic_refill_q,
	input wire instr_closely_coupled_mem_refetch_q,
	input wire rec_busy_q,
	input wire instr_closely_coupled_mem_wr_q,
	input wire [ADDR_W-1:0] instr_closely_coupled_mem_wr_addr_q,
	input wire [`CMER_DATA_W-1:0] instr_closely_coupled_mem_wr_data_q,
	input wire data_closely_coupled_mem_wr_q
);
	// single domain, reset silences every check
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_ic_count: assert property (
		ic_fetch_err && ic_cnt_q != '1 |=> ic_cnt_q == $past(ic_cnt_q) + 1'b1)
		else $error("icache counter did not step");
	a_ic_thresh: assert property (
		ic_fetch_err && ic_thresh != 0 && ic_cnt_q + 1'b1 == ic_thresh
		|=> corr_err_irq_q && irq_cause_q[`CMER_CAUSE_IC])
		else $error("icache threshold irq missing");
	a_cause_idle: assert property (!corr_err_irq_q |-> irq_cause_q == 3'h0)
		else $error("cause without irq");
	a_ic_recover: assert property (
		ic_fetch_err && !instr_closely_coupled_mem_fetch_err && !rec_busy_q |=> ic_inval_q && refetch_pc_flush_q
		&& ic_inval_set_q == $past(ic_err_set) ##1 ic_refill_q && !pipe_flush_q)
		else $error("icache recovery wrong");
	a_flush_pair: assert property (refetch_pc_flush_q == pipe_flush_q)
		else $error("flush pulses apart");
	a_instr_closely_coupled_mem_recover: assert property (
		instr_closely_coupled_mem_fetch_err && !rec_busy_q
		|=> refetch_pc_flush_q ##[2:8] instr_closely_coupled_mem_wr_q && instr_closely_coupled_mem_refetch_q)
		else $error("instr memory recovery wrong");
	a_spec_ignored: assert property (
		data_closely_coupled_mem_ls_err && data_closely_coupled_mem_ls_spec && !dma_rd_err |=> $stable(data_closely_coupled_mem_cnt_q))
		else $error("speculative error counted");
	a_data_closely_coupled_mem_fix: assert property (data_closely_coupled_mem_ls_err && !data_closely_coupled_mem_ls_spec |-> ##[1:4] data_closely_coupled_mem_wr_q)
		else $error("data memory fix not written");
	a_dma_wr: assert property (
		dma_wr_en && dma_wr_to_instr_closely_coupled_mem |=> instr_closely_coupled_mem_wr_q
		&& instr_closely_coupled_mem_wr_addr_q == $past(dma_wr_addr) && instr_closely_coupled_mem_wr_data_q == $past(dma_wr_data))
		else $error("dma write not passed");
	c_irq: cover property (corr_err_irq_q);
	c_instr_closely_coupled_mem_wb: cover property (instr_closely_coupled_mem_wr_q && instr_closely_coupled_mem_refetch_q);
	c_data_closely_coupled_mem_wb: cover property (data_closely_coupled_mem_wr_q);
endmodule
bind cmer_recovery cmer_recovery_properties #(
	.CNT_W(CNT_W), .ADDR_W(ADDR_W), .SET_W(SET_W)) u_props (.*);

// file: sim/cmer_mem_model.sv
`timescale 1ns/1ps
// far-side memories; only low address bits kept, tests stay in 256 words
module cmer_mem_model #(
	parameter ADDR_W = 16
) (
	input wire core_clk,
	input wire instr_closely_coupled_mem_wr_q,
	input wire [ADDR_W-1:0] instr_closely_coupled_mem_wr_addr_q,
	input wire [31:0] instr_closely_coupled_mem_wr_data_q,
	input wire data_closely_coupled_mem_wr_q,
	input wire [ADDR_W-1:0] data_closely_coupled_mem_wr_addr_q,
	input wire [31:0] data_closely_coupled_mem_wr_data_q
);
	logic [31:0] instr_closely_coupled_mem_mem [0:255];
	logic [31:0] data_closely_coupled_mem_mem [0:255];
	// whole words replace old content, unwritten words stay unknown
	// system-side memories fix and count their own errors, so none reach here
	always @(posedge core_clk) begin
		if (instr_closely_coupled_mem_wr_q) instr_closely_coupled_mem_mem[instr_closely_coupled_mem_wr_addr_q[7:0]] <= instr_closely_coupled_mem_wr_data_q;
		if (data_closely_coupled_mem_wr_q) data_closely_coupled_mem_mem[data_closely_coupled_mem_wr_addr_q[7:0]] <= data_closely_coupled_mem_wr_data_q;
	end
endmodule

// file: sim/cmer_recovery_bench.sv
`timescale 1ns/1ps
module cmer_recovery_bench;
	localparam CNT_W = 16;
	localparam ADDR_W = 16;
	localparam SET_W = 6;
	logic core_clk, rst_n, ic_fetch_err, instr_closely_coupled_mem_fetch_err, data_closely_coupled_mem_ls_err, data_closely_coupled_mem_ls_spec;
	logic dma_rd_err, dma_rd_to_instr_closely_coupled_mem, dma_wr_en, dma_wr_to_instr_closely_coupled_mem;
	logic [SET_W-1:0] ic_err_set;
	logic [ADDR_W-1:0] instr_closely_coupled_mem_fetch_addr, data_closely_coupled_mem_ls_addr, dma_rd_addr, dma_wr_addr;
	logic [31:0] instr_closely_coupled_mem_fetch_fix, data_closely_coupled_mem_ls_fix, dma_rd_fix, dma_wr_data;
	logic [CNT_W-1:0] ic_thresh, instr_closely_coupled_mem_thresh, data_closely_coupled_mem_thresh;
	wire [CNT_W-1:0] ic_cnt_q, instr_closely_coupled_mem_cnt_q, data_closely_coupled_mem_cnt_q;
	wire corr_err_irq_q, ic_inval_q, refetch_pc_flush_q, pipe_flush_q, ic_refill_q;
	wire instr_closely_coupled_mem_refetch_q, rec_busy_q, instr_closely_coupled_mem_wr_q, data_closely_coupled_mem_wr_q;
	wire [2:0] irq_cause_q;
	wire [SET_W-1:0] ic_inval_set_q;
	wire [ADDR_W-1:0] instr_closely_coupled_mem_wr_addr_q, data_closely_coupled_mem_wr_addr_q;
	wire [31:0] instr_closely_coupled_mem_wr_data_q, data_closely_coupled_mem_wr_data_q;
	wire [6:0] instr_closely_coupled_mem_wr_ecc_q, data_closely_coupled_mem_wr_ecc_q;
	integer err_total, tests_run;
	logic [2:0] cause_seen;
	logic [SET_W-1:0] inval_seen;
	cmer_recovery #(.CNT_W(CNT_W), .ADDR_W(ADDR_W), .SET_W(SET_W)) dut (.*);
	cmer_mem_model #(.ADDR_W(ADDR_W)) mdl (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// irq pulses last one cycle, so collect them as they pass
	always @(posedge core_clk) begin
		if (corr_err_irq_q === 1'b1) cause_seen <= cause_seen | irq_cause_q;
		if (ic_inval_q === 1'b1) inval_seen <= ic_inval_set_q;
	end
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	task chk(input bit ok, input string m);
		tests_run = tests_run + 1;
		if (!ok) begin
			$display("wrong value at %0t: %s", $time, m);
			err_total = err_total + 1;
		end
	endtask
	// bounded wait for idle, then let the memory write land
	task settle;
		integer i;
		for (i = 0; i < 20 && rec_busy_q !== 1'b0; i = i + 1) tick;
		tick;
		tick;
	endtask
	// second error lands while busy: counted, no second recovery
	task t_icache;
		ic_thresh = 16'h0002;
		ic_err_set = 6'h2A;
		ic_fetch_err = 1'b1;
		tick;
		ic_err_set = 6'h15;
		tick;
		ic_fetch_err = 1'b0;
		settle;
		chk(ic_cnt_q === 16'h0002, "icache count");
		chk(cause_seen === 3'h1, "icache cause");
		chk(inval_seen === 6'h2A, "invalidated set");
	endtask
	task t_instr_closely_coupled_mem;
		cause_seen = 3'h0;
		instr_closely_coupled_mem_thresh = 16'h0001;
		instr_closely_coupled_mem_fetch_addr = 16'h0010;
		instr_closely_coupled_mem_fetch_fix = 32'hC0DE1234;
		instr_closely_coupled_mem_fetch_err = 1'b1;
		tick;
		instr_closely_coupled_mem_fetch_err = 1'b0;
		settle;
		chk(instr_closely_coupled_mem_cnt_q === 16'h0001, "instr count");
		chk(cause_seen === 3'h2, "instr cause");
		chk(mdl.instr_closely_coupled_mem_mem[8'h10] === 32'hC0DE1234, "instr write back");
	endtask
	// speculative error first, then a committed one
	task t_data_closely_coupled_mem;
		cause_seen = 3'h0;
		data_closely_coupled_mem_thresh = 16'h0001;
		data_closely_coupled_mem_ls_addr = 16'h0020;
		data_closely_coupled_mem_ls_fix = 32'hAAAA5555;
		data_closely_coupled_mem_ls_spec = 1'b1;
		data_closely_coupled_mem_ls_err = 1'b1;
		tick;
		data_closely_coupled_mem_ls_err = 1'b0;
		settle;
		chk(data_closely_coupled_mem_cnt_q === 16'h0000 && cause_seen === 3'h0, "spec counted");
		data_closely_coupled_mem_ls_spec = 1'b0;
		data_closely_coupled_mem_ls_err = 1'b1;
		tick;
		data_closely_coupled_mem_ls_err = 1'b0;
		settle;
		chk(data_closely_coupled_mem_cnt_q === 16'h0001, "data count");
		chk(cause_seen === 3'h4, "data cause");
		chk(mdl.data_closely_coupled_mem_mem[8'h20] === 32'hAAAA5555, "data write back");
	endtask
	// counts pass threshold without a second irq; writes never count
	task t_dma;
		cause_seen = 3'h0;
		dma_rd_addr = 16'h0030;
		dma_rd_fix = 32'h13579BDF;
		dma_rd_to_instr_closely_coupled_mem = 1'b1;
		dma_rd_err = 1'b1;
		tick;
		dma_rd_to_instr_closely_coupled_mem = 1'b0;
		tick;
		dma_rd_err = 1'b0;
		settle;
		chk(instr_closely_coupled_mem_cnt_q === 16'h0002 && data_closely_coupled_mem_cnt_q === 16'h0002, "dma counts");
		chk(cause_seen === 3'h0, "irq past threshold");
		chk(mdl.instr_closely_coupled_mem_mem[8'h30] === 32'h13579BDF, "dma instr fix");
		chk(mdl.data_closely_coupled_mem_mem[8'h30] === 32'h13579BDF, "dma data fix");
		dma_wr_addr = 16'h0010;
		dma_wr_data = 32'h0F0FF0F0;
		dma_wr_to_instr_closely_coupled_mem = 1'b1;
		dma_wr_en = 1'b1;
		tick;
		dma_wr_to_instr_closely_coupled_mem = 1'b0;
		tick;
		dma_wr_en = 1'b0;
		settle;
		chk(mdl.instr_closely_coupled_mem_mem[8'h10] === 32'h0F0FF0F0, "dma instr write");
		chk(mdl.data_closely_coupled_mem_mem[8'h10] === 32'h0F0FF0F0, "dma data write");
		chk(instr_closely_coupled_mem_cnt_q === 16'h0002 && data_closely_coupled_mem_cnt_q === 16'h0002, "write counted");
	endtask
	task final_report;
		if (err_total == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		{rst_n, ic_fetch_err, instr_closely_coupled_mem_fetch_err, data_closely_coupled_mem_ls_err, data_closely_coupled_mem_ls_spec} = 5'h00;
		{dma_rd_err, dma_rd_to_instr_closely_coupled_mem, dma_wr_en, dma_wr_to_instr_closely_coupled_mem} = 4'h0;
		{ic_err_set, instr_closely_coupled_mem_fetch_addr, data_closely_coupled_mem_ls_addr, dma_rd_addr, dma_wr_addr} = '0;
		{instr_closely_coupled_mem_fetch_fix, data_closely_coupled_mem_ls_fix, dma_rd_fix, dma_wr_data} = '0;
		{ic_thresh, instr_closely_coupled_mem_thresh, data_closely_coupled_mem_thresh} = '0;
		err_total = 0;
		tests_run = 0;
		cause_seen = 3'h0;
		repeat (20) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_icache;
		t_instr_closely_coupled_mem;
		t_data_closely_coupled_mem;
		t_dma;
		final_report;
	end
	// all tests need well under 500 cycles
	initial begin
		#20000;
		err_total = err_total + 1;
		final_report;
	end
endmodule
